// File: adcc_core_model.sv
// conversion core stand-in that latches the analog value at the sample pulse
`timescale 1ns/1ps
module adcc_core_model (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_core_sample,
    input wire logic i_core_enable,
    input wire logic [9:0] i_value,
    output logic [9:0] o_result
);
    logic [9:0] held;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            held <= 10'h000;
        end else if (i_core_sample) begin
            held <= i_value;
        end
    end
    // powered-down core gives no valid code
    assign o_result = i_core_enable ? held : ~held;
endmodule // adcc_core_model

// File: adcc_ctrl.sv
// converter control, prescaler, conversion sequencer and result registers
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_ctrl
    import adcc_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:1] i_trigger_sources,
    input wire logic i_global_irq_enable,
    input wire logic i_irq_vector_ack,
    input wire logic [RES_W-1:0] i_core_result,
    output adcc_analog_sel_t o_analog_sel,
    output logic o_core_clk_tick,
    output logic o_core_sample,
    output logic o_core_enable,
    output logic o_conv_irq
);
    logic [7:0] sel_reg;
    logic [7:0] trig_reg;
    logic conv_enable;
    logic conv_running;
    logic auto_enable;
    logic done_flag;
    logic irq_enable;
    logic [2:0] div_select;
    logic [6:0] presc_cnt;
    logic [4:0] cyc_cnt;
    logic first_pending;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] pending_result;
    logic pending_valid;
    logic read_lock;
    logic [1:0] act_ref;
    logic [4:0] act_mux;
    logic [7:1] src_meta;
    logic [7:1] src_sync;
    logic enable_next;
    logic trig_prev;
    logic [7:0] trig_sync_in;
    adcc_state_t state;
    adcc_state_t next_state;
    logic [7:0] sel_byte;
    logic [7:0] ctrl_byte;
    logic [7:0] res_low;
    logic [7:0] res_high;
    logic [7:0] rd_byte;
    logic [6:0] div_top;
    logic tick;
    logic apb_write;
    logic apb_read;
    logic hit_sel;
    logic hit_ctrl;
    logic hit_low;
    logic hit_high;
    logic hit_trig;
    logic hit_any;
    logic wr_ctrl;
    logic start_write;
    logic trig_sel_level;
    logic trig_edge;
    logic free_running;
    logic start_req;
    logic [4:0] conv_len;
    logic conv_end;
    logic commit_result;
    logic [RES_W-1:0] done_result;
    logic done_set;
    logic done_clear;
    logic [4:0] sel_mux;

    // bus decode
    assign apb_write = psel && penable && pwrite;
    assign apb_read = psel && penable && !pwrite;
    assign hit_sel = (paddr == `ADCC_OFF_SELECT);
    assign hit_ctrl = (paddr == `ADCC_OFF_CTRL);
    assign hit_low = (paddr == `ADCC_OFF_RES_LOW);
    assign hit_high = (paddr == `ADCC_OFF_RES_HIGH);
    assign hit_trig = (paddr == `ADCC_OFF_TRIG);
    assign hit_any = hit_sel || hit_ctrl || hit_low || hit_high || hit_trig;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;
    assign wr_ctrl = apb_write && hit_ctrl && i_clk_en;

    // prescaler
    assign div_top = (div_select <= 3'd1) ? 7'd1 : 7'((8'd1 << div_select) - 8'd1); // RULE14
    assign tick = i_clk_en && conv_enable && (presc_cnt == div_top); // RULE14

    // trigger source select and edge detect
    assign trig_sync_in = {src_sync, done_flag};
    assign trig_sel_level = trig_sync_in[trig_reg[7:5]];
    assign free_running = (trig_reg[7:5] == 3'd0); // RULE21
    assign trig_edge = auto_enable && !free_running && trig_sel_level && !trig_prev; // RULE10

    // start written together with enable counts
    assign enable_next = wr_ctrl ? pwdata[`ADCC_BIT_ENABLE] : conv_enable; // RULE6 RULE8
    assign start_write = wr_ctrl && pwdata[`ADCC_BIT_START]; // RULE7 RULE9
    assign start_req = enable_next && (state != ADCC_CONV) && (start_write || trig_edge); // RULE7 RULE10
    assign conv_len = first_pending ? 5'(`ADCC_FIRST_CYCLES) : 5'(`ADCC_NORMAL_CYCLES); // RULE8
    assign conv_end = (state == ADCC_CONV) && tick && (cyc_cnt == conv_len - 5'd1);

    // result commit held off while low byte read is outstanding
    assign done_result = pending_valid ? pending_result : i_core_result;
    assign commit_result = i_clk_en && !read_lock && (conv_end || pending_valid); // RULE18
    assign done_set = commit_result; // RULE11
    assign done_clear = i_clk_en && ((wr_ctrl && pwdata[`ADCC_BIT_DONE]) || i_irq_vector_ack); // RULE12

    always_comb begin
        next_state = state;
        unique case (state)
            ADCC_IDLE: if (start_req) next_state = ADCC_CONV;
            ADCC_CONV: if (conv_end) next_state = ADCC_DONE;
            ADCC_DONE: begin
                if (auto_enable && free_running) begin
                    next_state = ADCC_CONV; // RULE22
                end else if (start_req) begin
                    next_state = ADCC_CONV;
                end else begin
                    next_state = ADCC_IDLE;
                end
            end
            default: next_state = ADCC_IDLE;
        endcase
        if (!enable_next) begin
            next_state = ADCC_IDLE; // RULE6
        end
    end

    // result presentation from live justification bit
    assign res_high = sel_reg[`ADCC_BIT_LEFT] ? result[9:2] : {6'h00, result[9:8]}; // RULE1 RULE2 RULE15 RULE16 RULE17
    assign res_low = sel_reg[`ADCC_BIT_LEFT] ? {result[1:0], 6'h00} : result[7:0]; // RULE1 RULE2 RULE15 RULE16
    assign sel_byte = sel_reg;
    assign ctrl_byte = {conv_enable, conv_running, auto_enable, done_flag, irq_enable, div_select}; // RULE9
    assign rd_byte = hit_sel ? sel_byte : hit_ctrl ? ctrl_byte : hit_low ? res_low :
        hit_high ? res_high : hit_trig ? {trig_reg[7:5], 5'h00} : 8'h00;
    assign o_conv_irq = done_flag && irq_enable && i_global_irq_enable; // RULE13

    // analog selection decode from the latched selection
    assign sel_mux = act_mux;
    always_comb begin
        o_analog_sel = '0;
        o_analog_sel.reference_select = act_ref; // RULE20
        o_analog_sel.input_gain_select = sel_mux;
        o_analog_sel.bandgap = (sel_mux == 5'h1E); // RULE4
        o_analog_sel.ground = (sel_mux == 5'h1F); // RULE4
        if (sel_mux[4:3] == 2'b00) begin
            o_analog_sel.pos_input = sel_mux[2:0]; // RULE4
        end else if (sel_mux[4:3] == 2'b01) begin
            o_analog_sel.differential = 1'b1; // RULE5
            o_analog_sel.pos_input = {1'b0, sel_mux[2], sel_mux[0]};
            o_analog_sel.neg_input = sel_mux[2] ? 2'd2 : 2'd0;
            o_analog_sel.gain_code = sel_mux[1] ? 2'd2 : 2'd1;
        end else if (sel_mux < 5'h1E) begin
            o_analog_sel.differential = 1'b1; // RULE5
            o_analog_sel.pos_input = sel_mux[2:0];
            o_analog_sel.neg_input = sel_mux[3] ? 2'd2 : 2'd1;
            o_analog_sel.gain_code = 2'd0;
        end
    end

    assign o_core_clk_tick = tick;
    assign o_core_sample = (state == ADCC_CONV) && tick && (cyc_cnt == 5'(`ADCC_SAMPLE_CYCLE));
    assign o_core_enable = conv_enable;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_reg <= `ADCC_RESET_BYTE;
            trig_reg <= `ADCC_RESET_BYTE;
            conv_enable <= 1'b0;
            auto_enable <= 1'b0;
            irq_enable <= 1'b0;
            div_select <= 3'd0;
        end else if (i_clk_en && apb_write) begin
            if (hit_sel) sel_reg <= pwdata[7:0];
            if (hit_trig) trig_reg <= {pwdata[7:5], 5'h00};
            if (hit_ctrl) begin
                conv_enable <= pwdata[`ADCC_BIT_ENABLE]; // RULE6
                auto_enable <= pwdata[`ADCC_BIT_AUTO];
                irq_enable <= pwdata[`ADCC_BIT_IRQ_EN];
                div_select <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ADCC_IDLE;
            presc_cnt <= 7'd0;
            cyc_cnt <= 5'd0;
            first_pending <= 1'b0;
            conv_running <= 1'b0;
            act_ref <= 2'd0;
            act_mux <= 5'd0;
        end else if (i_clk_en) begin
            state <= next_state;
            presc_cnt <= (!conv_enable || tick) ? 7'd0 : presc_cnt + 7'd1;
            if (wr_ctrl && pwdata[`ADCC_BIT_ENABLE] && !conv_enable) begin
                first_pending <= 1'b1; // RULE8
            end else if (conv_end) begin
                first_pending <= 1'b0;
            end
            if (next_state == ADCC_CONV && state != ADCC_CONV) begin
                cyc_cnt <= 5'd0;
            end else if (state == ADCC_CONV && tick) begin
                cyc_cnt <= cyc_cnt + 5'd1;
            end
            conv_running <= (next_state == ADCC_CONV); // RULE9
            if (state != ADCC_CONV) begin
                act_ref <= sel_reg[7:6]; // RULE20
                act_mux <= sel_reg[4:0]; // RULE3
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            result <= '0;
            pending_result <= '0;
            pending_valid <= 1'b0;
            read_lock <= 1'b0;
            done_flag <= 1'b0;
        end else if (i_clk_en) begin
            if (commit_result) result <= done_result;
            if (conv_end && read_lock) begin
                pending_result <= i_core_result; // RULE18
                pending_valid <= 1'b1;
            end else if (commit_result) begin
                pending_valid <= 1'b0;
            end
            if (apb_read && hit_low) begin
                read_lock <= 1'b1; // RULE18 RULE19
            end else if (apb_read && hit_high) begin
                read_lock <= 1'b0;
            end
            if (done_set) begin
                done_flag <= 1'b1; // RULE11
            end else if (done_clear) begin
                done_flag <= 1'b0; // RULE12
            end
        end
    end

    // trigger synchroniser, edge detect
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            src_meta <= 7'h00;
            src_sync <= 7'h00;
            trig_prev <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (i_clk_en) begin
            src_meta <= i_trigger_sources;
            src_sync <= src_meta;
            trig_prev <= trig_sel_level;
            prdata <= (psel && !penable && !pwrite) ? 32'h0000_0000 : prdata;
            if (psel && !pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end
endmodule // adcc_ctrl

// File: adcc_ctrl_assertions.sv
// port assertions for the converter control block
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_ctrl_assertions
    import adcc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic i_global_irq_enable,
    input wire logic i_irq_vector_ack,
    input wire adcc_analog_sel_t o_analog_sel,
    input wire logic o_core_clk_tick,
    input wire logic o_core_enable,
    input wire logic o_conv_irq
);
    wire logic [4:0] code = o_analog_sel.input_gain_select;
    wire logic [2:0] kind = {o_analog_sel.differential, o_analog_sel.bandgap, o_analog_sel.ground};
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    sequence ctrl_write(en);
        psel && penable && pwrite && i_clk_en && paddr == `ADCC_OFF_CTRL && pwdata[`ADCC_BIT_ENABLE] == en;
    endsequence
    sequence idle_ack;
        i_irq_vector_ack && !o_core_enable && !psel;
    endsequence
    chk_enable_set: assert property (ctrl_write(1'h1) |=> o_core_enable)
        else $error("converter not enabled after write");
    chk_enable_clear: assert property (ctrl_write(1'h0) |=> !o_core_enable [*2])
        else $error("converter still enabled after write");
    chk_irq_global: assert property (!i_global_irq_enable |-> !o_conv_irq)
        else $error("interrupt without global enable");
    chk_irq_ack: assert property (idle_ack |=> !o_conv_irq)
        else $error("interrupt kept after vector ack");
    chk_tick_gap: assert property (o_core_clk_tick |=> !o_core_clk_tick)
        else $error("converter clock faster than half");
    chk_single_decode: assert property (code < 5'h08 |-> kind == 3'h0 && o_analog_sel.pos_input == code[2:0])
        else $error("single ended decode wrong");
    chk_special_decode: assert property (code >= 5'h1E |-> kind == (code[0] ? 3'h1 : 3'h2))
        else $error("bandgap or ground decode wrong");
    chk_diff_decode: assert property (code inside {[5'h08:5'h1D]} |-> kind == 3'h4)
        else $error("differential decode wrong");
endmodule // adcc_ctrl_assertions

// File: adcc_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_ctrl_tb;
    import adcc_pkg::*;
    typedef struct packed {
        logic [4:0] code;
        logic [2:0] kind;
        logic [6:0] route;
        logic [2:0] div;
    } adcc_row_t;
    localparam logic [11:0] CTL = `ADCC_OFF_CTRL;
    localparam logic [11:0] LO = `ADCC_OFF_RES_LOW;
    localparam logic [11:0] HI = `ADCC_OFF_RES_HIGH;
    // code, {differential, bandgap, ground}, {pos, neg, gain}, divider code
    localparam adcc_row_t ROWS [8] = '{'{5'h03, 3'h0, 7'h30, 3'h0}, '{5'h07, 3'h0, 7'h70, 3'h1},
        '{5'h0B, 3'h4, 7'h12, 3'h2}, '{5'h0D, 3'h4, 7'h39, 3'h3}, '{5'h12, 3'h4, 7'h24, 3'h4},
        '{5'h1D, 3'h4, 7'h58, 3'h5}, '{5'h1E, 3'h2, 7'h00, 3'h6}, '{5'h1F, 3'h1, 7'h00, 3'h7}};
    logic i_ref_clk = 1'h0, i_resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, counting = 1'h0;
    logic i_global_irq_enable = 1'h0, i_irq_vector_ack = 1'h0, pready, pslverr, last_err;
    logic o_core_clk_tick, o_core_sample, o_core_enable, o_conv_irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [9:0] i_core_result, core_value = 10'h000;
    logic [7:0] q;
    logic [6:0] trig_src = 7'h00;
    logic [6:0] m;
    adcc_analog_sel_t o_analog_sel;
    int miscompares = 0, cmp_count = 0, cycles = 0, tick_cnt = 0, n;
    adcc_ctrl #(.RES_W(10)) DUT (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_clk_en(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_trigger_sources(trig_src), .i_global_irq_enable(i_global_irq_enable),
        .i_irq_vector_ack(i_irq_vector_ack), .i_core_result(i_core_result), .o_analog_sel(o_analog_sel),
        .o_core_clk_tick(o_core_clk_tick), .o_core_sample(o_core_sample), .o_core_enable(o_core_enable),
        .o_conv_irq(o_conv_irq));
    adcc_core_model u_core (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_core_sample(o_core_sample),
        .i_core_enable(o_core_enable), .i_value(core_value), .o_result(i_core_result));
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (counting && o_core_clk_tick === 1'h1 && o_conv_irq !== 1'h1) tick_cnt <= tick_cnt + 1;
        if (cycles == 10000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge i_ref_clk);
        penable <= 1'h1;
        do @(posedge i_ref_clk); while (pready !== 1'h1);
        q = prdata[7:0];
        last_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wait_irq();
        for (n = 0; n < 2000 && o_conv_irq !== 1'h1; n++) @(posedge i_ref_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_resetn <= 1'h1;
        foreach (ROWS[i]) begin
            bus(1'h1, `ADCC_OFF_SELECT, {3'h0, ROWS[i].code});
            bus(1'h1, CTL, {5'h10, ROWS[i].div});
            m = ROWS[i].kind[2] ? 7'h7F : (ROWS[i].kind == 3'h0 ? 7'h70 : 7'h00);
            chk("kind", {o_analog_sel.differential, o_analog_sel.bandgap, o_analog_sel.ground}, ROWS[i].kind);
            chk("route", {o_analog_sel.pos_input, o_analog_sel.neg_input, o_analog_sel.gain_code} & m, ROWS[i].route);
            for (n = 0; n < 300 && o_core_clk_tick !== 1'h1; n++) @(posedge i_ref_clk);
            n = 0;
            do begin
                @(posedge i_ref_clk);
                n++;
            end while (o_core_clk_tick !== 1'h1 && n < 300);
            chk("divide", n, 1 << (ROWS[i].div < 3'h2 ? 1 : ROWS[i].div));
        end
        $display("rows test done");
        i_resetn <= 1'h0;
        repeat (6) @(posedge i_ref_clk);
        i_resetn <= 1'h1;
        for (int a = 0; a < 5; a++) begin
            bus(1'h0, 12'(a * 4), 8'h00);
            chk("reset value", q, `ADCC_RESET_BYTE);
        end
        bus(1'h0, 12'h014, 8'h00);
        chk("unmapped", {last_err, q}, 9'h100);
        $display("reset test done");
        core_value <= 10'h270;
        i_global_irq_enable <= 1'h1;
        bus(1'h1, `ADCC_OFF_SELECT, 8'h0D);
        bus(1'h1, CTL, 8'hC8);
        counting <= 1'h1;
        tick_cnt <= 0;
        bus(1'h0, CTL, 8'h00);
        chk("busy", q, 8'hC8);
        wait_irq();
        chk("first ticks", tick_cnt, 25);
        counting <= 1'h0;
        bus(1'h0, LO, 8'h00);
        chk("right low", q, 8'h70);
        bus(1'h0, HI, 8'h00);
        chk("right high", q, 8'h02);
        bus(1'h1, `ADCC_OFF_SELECT, 8'h2D);
        bus(1'h0, LO, 8'h00);
        chk("left low", q, 8'h00);
        bus(1'h0, HI, 8'h00);
        chk("left high", q, 8'h9C);
        bus(1'h1, CTL, 8'h98);
        bus(1'h0, CTL, 8'h00);
        chk("flag clear", {o_conv_irq, q}, 9'h088);
        core_value <= 10'h155;
        bus(1'h1, CTL, 8'hC8);
        counting <= 1'h1;
        tick_cnt <= 0;
        wait_irq();
        chk("later ticks", tick_cnt, 13);
        counting <= 1'h0;
        bus(1'h0, LO, 8'h00);
        chk("lock low", q, 8'h40);
        core_value <= 10'h2AA;
        bus(1'h1, CTL, 8'hD8);
        bus(1'h1, `ADCC_OFF_SELECT, 8'h2E);
        chk("pending sel", o_analog_sel.input_gain_select, 5'h0D);
        repeat (60) @(posedge i_ref_clk);
        chk("held flag", o_conv_irq, 1'h0);
        bus(1'h0, HI, 8'h00);
        chk("held high", q, 8'h55);
        wait_irq();
        chk("new sel", {o_conv_irq, o_analog_sel.input_gain_select}, 6'h2E);
        bus(1'h0, LO, 8'h00);
        chk("new low", q, 8'h80);
        bus(1'h0, HI, 8'h00);
        chk("new high", q, 8'hAA);
        $display("conversion test done");
        bus(1'h1, CTL, 8'h08);
        i_global_irq_enable <= 1'h0;
        @(posedge i_ref_clk);
        chk("masked", o_conv_irq, 1'h0);
        i_global_irq_enable <= 1'h1;
        @(posedge i_ref_clk);
        chk("unmasked", o_conv_irq, 1'h1);
        i_irq_vector_ack <= 1'h1;
        @(posedge i_ref_clk);
        i_irq_vector_ack <= 1'h0;
        @(posedge i_ref_clk);
        chk("acked", o_conv_irq, 1'h0);
        bus(1'h1, `ADCC_OFF_TRIG, 8'h20);
        bus(1'h1, CTL, 8'hB8);
        trig_src <= 7'h01;
        wait_irq();
        chk("auto trigger", o_conv_irq, 1'h1);
        trig_src <= 7'h00;
        bus(1'h1, CTL, 8'hD0);
        bus(1'h1, CTL, 8'h00);
        repeat (60) @(posedge i_ref_clk);
        bus(1'h0, CTL, 8'h00);
        chk("abort", {o_core_enable, q}, 9'h000);
        $display("irq and abort test done");
        finish_test();
    end
endmodule // adcc_ctrl_tb
bind adcc_ctrl adcc_ctrl_assertions u_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .i_global_irq_enable(i_global_irq_enable), .i_irq_vector_ack(i_irq_vector_ack),
    .o_analog_sel(o_analog_sel), .o_core_clk_tick(o_core_clk_tick), .o_core_enable(o_core_enable),
    .o_conv_irq(o_conv_irq));

// File: adcc_defs.svh
// constants for the converter control and result register block
// Functional notes
// RULE1: left_justify_select high gives left-justified result, low gives right-justified.
// RULE2: justification change alters result presentation immediately, even mid-conversion.
// RULE3: input_gain_select written mid-conversion applies only once conversion completes.
// RULE4: codes 0-7 single-ended inputs; 11110 bandgap, 11111 ground; not differential.
// RULE5: codes 01000-11101 select differential pairs with gains per selection table.
// RULE6: converter_enable one enables; zero turns off and aborts running conversion.
// RULE7: start write begins conversion; free-running needs it only for the first.
// RULE8: first conversion after enable takes 25 converter clocks, later ones 13.
// RULE9: conversion_start reads one while converting; writing zero does nothing.
// RULE10: auto-trigger starts a conversion on each rising edge of selected trigger.
// RULE11: done flag sets when conversion finishes and result registers are updated.
// RULE12: done flag cleared by interrupt vector acknowledge or by writing one.
// RULE13: interrupt requested while done flag, its enable and global enable are set.
// RULE14: divider codes 000/001 give 2, then 4 up to 128.
// RULE15: right justify: high byte holds bits 9:8 low, low byte bits 7:0.
// RULE16: left justify: high byte bits 9:2, low byte bits 1:0 in 7:6.
// RULE17: differential results are presented in two's complement form; the code passes the core result through unchanged for every input code.
// RULE18: after low byte read, result not updated until high byte read.
// RULE19: software reads low byte before high byte, or high byte alone.
// RULE20: reference_select chooses reference; mid-conversion change applies after completion.
// RULE21: trigger_source_select zero is free running; switching to it makes no trigger.
// RULE22: free running restarts conversion right after each completion while enabled.
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define ADCC_OFF_SELECT 12'h000
`define ADCC_OFF_CTRL 12'h004
`define ADCC_OFF_RES_LOW 12'h008
`define ADCC_OFF_RES_HIGH 12'h00C
`define ADCC_OFF_TRIG 12'h010
`define ADCC_RESET_BYTE 8'h00
`define ADCC_BIT_ENABLE 7
`define ADCC_BIT_START 6
`define ADCC_BIT_AUTO 5
`define ADCC_BIT_DONE 4
`define ADCC_BIT_IRQ_EN 3
`define ADCC_BIT_LEFT 5
`define ADCC_FIRST_CYCLES 25
`define ADCC_NORMAL_CYCLES 13
`define ADCC_SAMPLE_CYCLE 1
`endif

// File: adcc_pkg.sv
// types for the converter control and result register block
package adcc_pkg;
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_CONV = 2'b01,
        ADCC_DONE = 2'b11
    } adcc_state_t;
    typedef struct packed {
        logic [1:0] reference_select;
        logic [4:0] input_gain_select;
        logic differential;
        logic bandgap;
        logic ground;
        logic [2:0] pos_input;
        logic [1:0] neg_input;
        logic [1:0] gain_code;
    } adcc_analog_sel_t;
endpackage
